// ===== src/dbs_bus_sizer.sv
// External bus dynamic port sizing and operand alignment engine
`timescale 1ns/1ns
`include "dbs_regs.svh"
module dbs_bus_sizer
    import dbs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    // Operand requests from the core
    input  wire logic        cmdValid,
    output logic             cmdReady,
    input  wire logic        cmdWrite,
    input  wire logic [1:0]  cmdSize,
    input  wire logic [19:0] cmdAddr,
    input  wire logic [31:0] cmdWdata,
    output logic             rdValid,
    output logic [31:0]      rdData,
    // Chip-select acknowledge, same clock
    input  wire logic        csAckValid,
    input  wire logic        csAckUpper,
    input  wire logic        csAckLower,
    // External bus pins
    output logic [23:0]      busAddr,
    output logic             xferSizeHi,
    output logic             xferSizeLo,
    output logic             readNotWrite,
    output logic             addrStrobeN,
    output logic             dataStrobeN,
    output logic [15:0]      dataOut,
    output logic             dataOe,
    input  wire logic [15:0] dataIn,
    input  wire logic        portAckUpperN,
    input  wire logic        portAckLowerN
);
    dbs_core_t r_reg;
    dbs_core_t r_next;

    logic [`DBS_CMD_W-1:0] fifoIn;
    logic [`DBS_CMD_W-1:0] fifoOut;
    logic        fifoValid;
    logic        fifoPop;
    logic [1:0]  ackSync;
    logic [15:0] dataSync;
    logic        ackUpper;
    logic        ackLower;
    logic        port8;
    logic        port16;
    logic        moveTwo;
    logic        qWrite;
    logic [1:0]  qSize;
    logic [19:0] qAddr;
    logic [31:0] qData;

    assign fifoIn  = {cmdWrite, cmdSize, cmdAddr, cmdWdata};
    assign qWrite  = fifoOut[`DBS_CMD_WRITE_BIT];
    assign qSize   = fifoOut[`DBS_CMD_SIZE_LSB +: 2];
    assign qAddr   = fifoOut[`DBS_CMD_ADDR_LSB +: `DBS_ADDR_W];
    assign qData   = fifoOut[`DBS_CMD_WDATA_LSB +: 32];
    assign fifoPop = fifoValid & (r_reg.state == DBS_IDLE);

    // Full FIFO stalls the core through cmdReady
    dbs_fifo #(
        .WIDTH (`DBS_CMD_W),
        .DEPTH (`DBS_FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (cmdValid),
        .inReady  (cmdReady),
        .inData   (fifoIn),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoOut)
    );

    dbs_sync3 #(
        .W    (2),
        .INIT (`DBS_ACK_IDLE)
    ) u_ack_sync (
        .clk     (clk),
        .rst     (rst),
        .pinIn   ({portAckUpperN, portAckLowerN}),
        .syncOut (ackSync)
    );

    // Data passes the same depth as the acknowledge, so both line up
    dbs_sync3 #(
        .W    (16),
        .INIT (16'h0000)
    ) u_data_sync (
        .clk     (clk),
        .rst     (rst),
        .pinIn   (dataIn),
        .syncOut (dataSync)
    );

    // Internal acknowledge overrides the pins while valid
    always_comb
    begin
        if (csAckValid)
        begin
            ackUpper = csAckUpper;
            ackLower = csAckLower;
        end
        else
        begin
            ackUpper = ~ackSync[1];
            ackLower = ~ackSync[0];
        end
    end

    // Reserved both-asserted code and none asserted both keep waiting
    // Lower alone is an 8-bit port, upper alone a 16-bit port
    assign port8   = ~ackUpper & ackLower;
    assign port16  = ackUpper & ~ackLower;
    // Two bytes only when aligned, at least two left and a 16-bit port
    assign moveTwo = port16 & ~r_reg.addr[0] & (r_reg.rem >= 3'd2);

    // Drives address, size, direction and write lanes for the next cycle
    function automatic dbs_core_t setup_pins(input dbs_core_t s);
        dbs_core_t t;
        t = s;
        t.busAddr      = {{4{s.addr[19]}}, s.addr};
        // Remaining count 1..4 maps onto the size code by its low bits
        t.sizeCode     = s.rem[1:0];
        t.readNotWrite = ~s.write;
        t.dataOe       = s.write;
        if (s.rem >= 3'd2 && !s.addr[0])
        begin
            t.dataOut = s.data[31:16];
        end
        else
        begin
            t.dataOut = {s.data[31:24], s.data[31:24]};
        end
        return t;
    endfunction : setup_pins

    always_comb
    begin
        r_next         = r_reg;
        r_next.rdValid = 1'b0;
        unique case (r_reg.state)
            DBS_IDLE:
            begin
                if (fifoValid)
                begin
                    r_next.write = qWrite;
                    r_next.addr  = qAddr;
                    r_next.acc   = 32'h0000_0000;
                    r_next.pend  = 1'b0;
                    unique case (qSize)
                        `DBS_SIZE_BYTE:
                        begin
                            r_next.rem  = 3'd1;
                            r_next.data = {qData[7:0], 24'h00_0000};
                        end
                        `DBS_SIZE_LONG:
                        begin
                            r_next.data = qData;
                            if (qAddr[0])
                            begin
                                r_next.rem  = 3'd2;
                                r_next.pend = 1'b1;
                            end
                            else
                            begin
                                r_next.rem = 3'd4;
                            end
                        end
                        default:
                        begin
                            // Word; three-byte is never requested by the core
                            r_next.rem  = 3'd2;
                            r_next.data = {qData[15:0], 16'h0000};
                        end
                    endcase
                    r_next       = setup_pins(r_next);
                    r_next.state = DBS_START;
                end
            end
            DBS_START:
            begin
                r_next.addrStrobeN = 1'b0;
                // Read strobes data with address; write waits a cycle for data
                r_next.dataStrobeN = r_reg.write;
                r_next.state       = DBS_STROBE;
            end
            DBS_STROBE:
            begin
                r_next.dataStrobeN = 1'b0;
                if (port8 || port16)
                begin
                    if (moveTwo)
                    begin
                        r_next.acc  = {r_reg.acc[15:0], dataSync};
                        r_next.data = {r_reg.data[15:0], 16'h0000};
                        r_next.rem  = r_reg.rem - 3'd2;
                        r_next.addr = r_reg.addr + 20'h0_0002;
                    end
                    else
                    begin
                        if (port16 && r_reg.addr[0])
                        begin
                            r_next.acc = {r_reg.acc[23:0], dataSync[7:0]};
                        end
                        else
                        begin
                            r_next.acc = {r_reg.acc[23:0], dataSync[15:8]};
                        end
                        r_next.data = {r_reg.data[23:0], 8'h00};
                        r_next.rem  = r_reg.rem - 3'd1;
                        r_next.addr = r_reg.addr + 20'h0_0001;
                    end
                    r_next.addrStrobeN = `DBS_STRB_IDLE;
                    r_next.dataStrobeN = `DBS_STRB_IDLE;
                    r_next.state       = DBS_END;
                end
            end
            DBS_END:
            begin
                // Hold off the next cycle until the acknowledge is released
                if (!ackUpper && !ackLower)
                begin
                    if (r_reg.rem != 3'd0)
                    begin
                        r_next       = setup_pins(r_reg);
                        r_next.state = DBS_START;
                    end
                    else if (r_reg.pend)
                    begin
                        r_next.rem   = 3'd2;
                        r_next.pend  = 1'b0;
                        r_next       = setup_pins(r_next);
                        r_next.state = DBS_START;
                    end
                    else
                    begin
                        r_next.rdValid = ~r_reg.write;
                        r_next.rdData  = r_reg.acc;
                        r_next.dataOe  = 1'b0;
                        r_next.state   = DBS_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            r_reg              <= '0;
            r_reg.state        <= DBS_IDLE;
            r_reg.readNotWrite <= 1'b1;
            r_reg.addrStrobeN  <= `DBS_STRB_IDLE;
            r_reg.dataStrobeN  <= `DBS_STRB_IDLE;
            r_reg.sizeCode     <= `DBS_SIZE_BYTE;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign rdValid      = r_reg.rdValid;
    assign rdData       = r_reg.rdData;
    assign busAddr      = r_reg.busAddr;
    assign xferSizeHi   = r_reg.sizeCode[1];
    assign xferSizeLo   = r_reg.sizeCode[0];
    assign readNotWrite = r_reg.readNotWrite;
    assign addrStrobeN  = r_reg.addrStrobeN;
    assign dataStrobeN  = r_reg.dataStrobeN;
    assign dataOut      = r_reg.dataOut;
    assign dataOe       = r_reg.dataOe;
endmodule : dbs_bus_sizer

// ===== src/dbs_fifo.sv
// Command FIFO with valid/ready on both sides
`timescale 1ns/1ns
module dbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   count;
        logic          notFull;
    } dbs_fifo_t;

    dbs_fifo_t  st_reg;
    dbs_fifo_t  st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic       push;
    logic       pop;

    // Ready comes straight from a flop so the core sees no comparator path
    assign inReady  = st_reg.notFull;
    assign outValid = (st_reg.count != '0);
    assign outData  = mem[st_reg.rdPtr];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.wrPtr = (st_reg.wrPtr == AW'(DEPTH - 1)) ? '0 : st_reg.wrPtr + 1'b1;
        end
        if (pop)
        begin
            st_next.rdPtr = (st_reg.rdPtr == AW'(DEPTH - 1)) ? '0 : st_reg.rdPtr + 1'b1;
        end
        st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
        st_next.notFull = (st_next.count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '0;
            st_reg.notFull <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[st_reg.wrPtr] <= inData;
        end
    end
endmodule : dbs_fifo

// ===== src/dbs_pkg.sv
// Types of the dynamic bus sizing block
package dbs_pkg;

    typedef enum logic [1:0] {
        DBS_IDLE   = 2'b00,
        DBS_START  = 2'b01,
        DBS_STROBE = 2'b10,
        DBS_END    = 2'b11
    } dbs_state_t;

    typedef struct packed {
        dbs_state_t  state;
        logic [2:0]  rem;
        logic        pend;
        logic        write;
        logic [19:0] addr;
        logic [31:0] data;
        logic [31:0] acc;
        logic [23:0] busAddr;
        logic [1:0]  sizeCode;
        logic        readNotWrite;
        logic        addrStrobeN;
        logic        dataStrobeN;
        logic [15:0] dataOut;
        logic        dataOe;
        logic        rdValid;
        logic [31:0] rdData;
    } dbs_core_t;

endpackage : dbs_pkg

// ===== src/dbs_regs.svh
// Constants of the dynamic bus sizing block
// Contract
// - Acknowledge pair selects wait, 8-bit, 16-bit, reserved
// - Long word takes two 16-bit or four 8-bit reads
// - 16-bit port on lanes 15:0, 8-bit on 15:8
// - Move most data per cycle, assume 16-bit first
// - Operand bytes go most significant first
// - Size outputs give bytes still to move
// - Address carries word base plus byte offset
// - Address bits 23:20 copy address bit 19
// - Word and long word misaligned at odd address
// - At most an aligned word per cycle, high word first
// - Misaligned long word runs as two misaligned words
// - Single byte lane choice, duplicated when writing
// - Word cycle sequences per port width and alignment
// - Aligned long word starts coded long word
// - Long word to 8-bit continues three-byte cycle
// - Three-byte cycle odd, then aligned word cycle
// - Chip-select logic may supply the acknowledge
// - Size codes byte 01, word 10, three 11, long 00
// - Writes drive all sixteen data lines
`ifndef DBS_REGS_SVH
`define DBS_REGS_SVH

`define DBS_SIZE_BYTE   2'b01
`define DBS_SIZE_WORD   2'b10
`define DBS_SIZE_THREE  2'b11
`define DBS_SIZE_LONG   2'b00

`define DBS_ADDR_W      20
`define DBS_BUS_ADDR_W  24
`define DBS_CMD_W       55
`define DBS_CMD_WDATA_LSB 0
`define DBS_CMD_ADDR_LSB  32
`define DBS_CMD_SIZE_LSB  52
`define DBS_CMD_WRITE_BIT 54

`define DBS_FIFO_DEPTH  8
`define DBS_STRB_IDLE   1'b1
`define DBS_ACK_IDLE    2'b11

`endif

// ===== src/dbs_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module dbs_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dbs_sync_t;

    dbs_sync_t st_reg;
    dbs_sync_t st_next;

    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = pinIn;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // First stage may be metastable, so only later stages are compared
        if (st_reg.s2 == st_reg.s3)
        begin
            st_next.q = st_reg.s3;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= {INIT, INIT, INIT, INIT};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign syncOut = st_reg.q;
endmodule : dbs_sync3

// ===== testbench/dbs_bus_sizer_properties.sv
// Pin-level checks on the bus sizing engine
`timescale 1ns/1ns
module dbs_bus_sizer_properties (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        csAckValid,
    input wire logic        csAckUpper,
    input wire logic        csAckLower,
    input wire logic [23:0] busAddr,
    input wire logic        xferSizeHi,
    input wire logic        xferSizeLo,
    input wire logic        readNotWrite,
    input wire logic        addrStrobeN,
    input wire logic        dataStrobeN,
    input wire logic [15:0] dataOut,
    input wire logic        dataOe,
    input wire logic        portAckUpperN,
    input wire logic        portAckLowerN
);
    wire logic [1:0] sz = {xferSizeHi, xferSizeLo};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence pinAck;
        !dataStrobeN && (portAckUpperN != portAckLowerN) && !csAckValid;
    endsequence
    sequence noAck;
        !dataStrobeN && portAckUpperN && portAckLowerN && !csAckValid;
    endsequence
    sequence csAck16;
        csAckValid && csAckUpper && !csAckLower && !dataStrobeN;
    endsequence
    addr_copy_a: assert property (busAddr[23:20] == {4{busAddr[19]}})
        else $error("upper address bits differ from bit 19");
    ack_ends_a: assert property (pinAck [*3] |-> ##[1:3] dataStrobeN)
        else $error("acknowledged cycle did not end");
    wait_holds_a: assert property (noAck [*4] |=> !dataStrobeN)
        else $error("cycle ended without acknowledge");
    cs_ends_a: assert property (csAck16 |=> dataStrobeN && addrStrobeN)
        else $error("chip-select acknowledge ignored");
    write_drive_a: assert property (!addrStrobeN && !readNotWrite |-> dataOe)
        else $error("write cycle not driving data lines");
    read_float_a: assert property (!addrStrobeN && readNotWrite |-> !dataOe)
        else $error("read cycle driving data lines");
    byte_dup_a: assert property (!dataStrobeN && !readNotWrite && sz == 2'b01 |-> dataOut[15:8] == dataOut[7:0])
        else $error("written byte not on both lanes");
    long_even_a: assert property (!addrStrobeN && sz == 2'b00 |-> !busAddr[0])
        else $error("long word code at odd address");
    three_odd_a: assert property (!addrStrobeN && sz == 2'b11 |-> busAddr[0])
        else $error("three byte code at even address");
    hold_pins_a: assert property (!addrStrobeN && !$past(addrStrobeN) |-> $stable(busAddr) && $stable(sz))
        else $error("address or size moved inside cycle");
endmodule : dbs_bus_sizer_properties

bind dbs_bus_sizer dbs_bus_sizer_properties chk (.clk, .rst, .csAckValid, .csAckUpper, .csAckLower, .busAddr,
    .xferSizeHi, .xferSizeLo, .readNotWrite, .addrStrobeN, .dataStrobeN, .dataOut, .dataOe, .portAckUpperN,
    .portAckLowerN);

// ===== testbench/dbs_mem_model.sv
// Behavioural external memory with 8-bit or 16-bit port acknowledge
`timescale 1ns/1ns
module dbs_mem_model (
    input  wire logic        clk,
    input  wire logic        wide,
    input  wire logic        ackOn,
    input  wire logic [3:0]  lag,
    input  wire logic [23:0] busAddr,
    input  wire logic        xferSizeHi,
    input  wire logic        xferSizeLo,
    input  wire logic        readNotWrite,
    input  wire logic        addrStrobeN,
    input  wire logic        dataStrobeN,
    input  wire logic [15:0] dataOut,
    output logic      [15:0] dataIn,
    output logic             portAckUpperN,
    output logic             portAckLowerN
);
    logic [7:0]  mem [0:255];
    logic [11:0] trace;
    logic [3:0]  cnt;
    logic        asPrev;
    logic [7:0]  a;
    initial
    begin
        foreach (mem[i]) mem[i] = 8'h00;
        {portAckUpperN, portAckLowerN, asPrev} = 3'b111;
        dataIn = 16'h0000;
        trace = 12'h000;
        cnt = 4'h0;
    end
    always @(posedge clk)
    begin
        a = busAddr[7:0];
        asPrev <= addrStrobeN;
        if (!addrStrobeN && asPrev)
            trace <= {trace[8:0], xferSizeHi, xferSizeLo, a[0]};
        if (addrStrobeN || dataStrobeN || cnt < lag)
        begin
            // Released lanes keep toggling so stale data never looks valid
            dataIn <= ~dataIn;
            {portAckUpperN, portAckLowerN} <= 2'b11;
            cnt <= dataStrobeN ? 4'h0 : cnt + 4'h1;
        end
        else
        begin
            dataIn <= wide ? {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]} : {mem[a], ~mem[a]};
            if (ackOn)
                {portAckUpperN, portAckLowerN} <= wide ? 2'b01 : 2'b10;
            if (!readNotWrite && portAckUpperN && portAckLowerN)
            begin
                if (!wide)
                    mem[a] = dataOut[15:8];
                else if (a[0])
                    mem[a] = dataOut[7:0];
                else
                begin
                    mem[a] = dataOut[15:8];
                    if ({xferSizeHi, xferSizeLo} != 2'b01)
                        mem[a + 8'h01] = dataOut[7:0];
                end
            end
        end
    end
endmodule : dbs_mem_model

// ===== testbench/dynamic_bus_sizing_test.sv
// Self-checking bench for the bus sizing engine
`timescale 1ns/1ns
module dynamic_bus_sizing_test;
    logic        clk, rst, cmdValid, cmdReady, cmdWrite, rdValid, csMode, csAckLower, wide, ackOn, refused;
    logic        xferSizeHi, xferSizeLo, readNotWrite, addrStrobeN, dataStrobeN, dataOe, portAckUpperN, portAckLowerN;
    logic        csAckUpper;
    logic [1:0]  cmdSize;
    logic [19:0] cmdAddr;
    logic [31:0] cmdWdata, rdData;
    logic [23:0] busAddr;
    logic [15:0] dataOut, dataIn;
    logic [3:0]  lag, csCnt;
    int          failures, comparisons;

    dbs_bus_sizer dut (.clk, .rst, .cmdValid, .cmdReady, .cmdWrite, .cmdSize, .cmdAddr, .cmdWdata, .rdValid,
        .rdData, .csAckValid(csMode), .csAckUpper, .csAckLower, .busAddr, .xferSizeHi, .xferSizeLo,
        .readNotWrite, .addrStrobeN, .dataStrobeN, .dataOut, .dataOe, .dataIn, .portAckUpperN, .portAckLowerN);
    dbs_mem_model mdl (.clk, .wide, .ackOn, .lag, .busAddr, .xferSizeHi, .xferSizeLo, .readNotWrite,
        .addrStrobeN, .dataStrobeN, .dataOut, .dataIn, .portAckUpperN, .portAckLowerN);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Chip-select stand-in waits so the synchronised read data has settled
    // Upper alone claims a 16-bit port, lower alone an 8-bit port
    always @(negedge clk)
    begin
        csCnt <= dataStrobeN ? 4'h0 : csCnt + 4'h1;
        csAckUpper <= csMode && !dataStrobeN && csCnt > 4'h4 && wide;
        csAckLower <= csMode && !dataStrobeN && csCnt > 4'h4 && !wide;
    end

    always @(posedge clk)
        if (cmdValid && !cmdReady)
            refused <= 1'b1;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
            failures++;
        end
    endtask : check

    // Entered at a falling edge; leaves the request up for the caller
    task automatic put(input logic wr, input logic [1:0] sz, input logic [19:0] a, input logic [31:0] d);
        int t;
        {cmdValid, cmdWrite, cmdSize, cmdAddr, cmdWdata} = {1'b1, wr, sz, a, d};
        t = 0;
        while (cmdReady !== 1'b1 && t < 3000)
        begin
            @(negedge clk);
            t++;
        end
        check("cmd accepted", cmdReady, 1'b1);
        @(posedge clk);
        @(negedge clk);
    endtask : put

    task automatic wait_rd();
        int t;
        t = 0;
        while (rdValid !== 1'b1 && t < 3000)
        begin
            @(negedge clk);
            t++;
        end
        check("read done", rdValid, 1'b1);
    endtask : wait_rd

    task automatic rt(input logic w, input logic [1:0] sz, input logic [19:0] a, input logic [31:0] d,
                      input logic [11:0] tr, input int n);
        logic [15:0] m;
        logic [31:0] k;
        m = (16'h0001 << (3 * n)) - 16'h0001;
        k = (sz == 2'b01) ? 32'h0000_00ff : (sz == 2'b10) ? 32'h0000_ffff : 32'hffff_ffff;
        wide = w;
        put(1'b1, sz, a, d);
        put(1'b0, sz, a, 32'h0000_0000);
        cmdValid = 1'b0;
        wait_rd();
        check("read data", rdData, d & k);
        check("cycle trace", {20'h00000, mdl.trace & m[11:0]}, {20'h00000, tr & m[11:0]});
    endtask : rt

    task automatic s_bytes();
        rt(1'b0, 2'b01, 20'h00010, 32'h0000_00a5, 12'h002, 1);
        rt(1'b0, 2'b01, 20'h00011, 32'h0000_003c, 12'h003, 1);
        rt(1'b1, 2'b01, 20'h00012, 32'h0000_0096, 12'h002, 1);
        rt(1'b1, 2'b01, 20'h00013, 32'h0000_0069, 12'h003, 1);
    endtask : s_bytes

    task automatic s_words();
        rt(1'b0, 2'b10, 20'h00014, 32'h0000_1357, 12'h023, 2);
        rt(1'b0, 2'b10, 20'h00017, 32'h0000_2468, 12'h02a, 2);
        rt(1'b1, 2'b10, 20'h0001a, 32'h0000_9bdf, 12'h004, 1);
        rt(1'b1, 2'b10, 20'h0001d, 32'h0000_ace0, 12'h02a, 2);
    endtask : s_words

    task automatic s_longs();
        rt(1'b0, 2'b00, 20'h00020, 32'h1122_3344, 12'h1e3, 4);
        rt(1'b1, 2'b00, 20'h00028, 32'h5566_7788, 12'h004, 2);
        rt(1'b1, 2'b00, 20'h00031, 32'h99aa_bbcc, 12'haaa, 4);
        rt(1'b0, 2'b00, 20'h00039, 32'hddee_f012, 12'haaa, 4);
    endtask : s_longs

    task automatic s_wait();
        lag = 4'hf;
        rt(1'b1, 2'b10, 20'h00050, 32'h0000_4321, 12'h004, 1);
        lag = 4'h0;
    endtask : s_wait

    task automatic s_cs();
        {csMode, ackOn} = 2'b10;
        rt(1'b1, 2'b01, 20'h00061, 32'h0000_00c3, 12'h003, 1);
        rt(1'b1, 2'b10, 20'h00062, 32'h0000_7e81, 12'h004, 1);
        rt(1'b0, 2'b10, 20'h00064, 32'h0000_5aa5, 12'h023, 2);
        {csMode, ackOn} = 2'b01;
    endtask : s_cs

    task automatic s_fill();
        lag = 4'hf;
        wide = 1'b1;
        refused = 1'b0;
        for (int i = 0; i < 12; i++)
            put(1'b1, 2'b01, 20'h00070 + 20'(i), 32'(i) + 32'h0000_0010);
        put(1'b0, 2'b01, 20'h00070, 32'h0000_0000);
        put(1'b0, 2'b01, 20'h0007b, 32'h0000_0000);
        cmdValid = 1'b0;
        check("fifo refused", refused, 1'b1);
        lag = 4'h0;
        wait_rd();
        check("first queued byte", rdData, 32'h0000_0010);
        @(negedge clk);
        wait_rd();
        check("last queued byte", rdData, 32'h0000_001b);
    endtask : s_fill

    task automatic tally_and_finish();
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #800000;
        failures++;
        tally_and_finish();
    end

    initial
    begin
        {rst, cmdValid, cmdWrite, cmdSize, cmdAddr, cmdWdata} = {1'b1, 1'b0, 1'b0, 2'b01, 20'h00000, 32'h0};
        {csMode, csAckUpper, csAckLower, csCnt, wide, ackOn, lag, refused} = {1'b0, 2'b00, 4'h0, 1'b1, 1'b1, 4'h0, 1'b0};
        failures = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        s_bytes();
        s_words();
        s_longs();
        s_wait();
        s_cs();
        s_fill();
        tally_and_finish();
    end
endmodule : dynamic_bus_sizing_test
